// *** design/cfgio_pkg.sv ***
// Package with register map, reset values and types for the configurable port pin block.
package cfgio_pkg;
	localparam int unsigned CFGIO_P0_W = 8;
	localparam int unsigned CFGIO_P1_W = 8;
	localparam int unsigned CFGIO_P3_W = 2;
	localparam int unsigned CFGIO_NPIN = 18;
	localparam int unsigned CFGIO_P1_BASE = 8;
	localparam int unsigned CFGIO_P3_BASE = 16;
	localparam int unsigned CFGIO_P1_B2 = CFGIO_P1_BASE + 2;
	localparam int unsigned CFGIO_P1_B3 = CFGIO_P1_BASE + 3;
	localparam int unsigned CFGIO_P1_B5 = CFGIO_P1_BASE + 5;
	localparam int unsigned CFGIO_P3_B0 = CFGIO_P3_BASE;
	localparam int unsigned CFGIO_P3_B1 = CFGIO_P3_BASE + 1;
	localparam int unsigned CFGIO_P1_B5_LOCAL = 5;
	localparam logic [11:0] CFGIO_OFS_P0_LATCH = 12'h000;
	localparam logic [11:0] CFGIO_OFS_P0_MODE_A = 12'h004;
	localparam logic [11:0] CFGIO_OFS_P0_MODE_B = 12'h008;
	localparam logic [11:0] CFGIO_OFS_P1_LATCH = 12'h010;
	localparam logic [11:0] CFGIO_OFS_P1_MODE_A = 12'h014;
	localparam logic [11:0] CFGIO_OFS_P1_MODE_B = 12'h018;
	localparam logic [11:0] CFGIO_OFS_P3_LATCH = 12'h020;
	localparam logic [11:0] CFGIO_OFS_P3_MODE_A = 12'h024;
	localparam logic [11:0] CFGIO_OFS_P3_MODE_B = 12'h028;
	localparam logic [11:0] CFGIO_OFS_AN_OFF = 12'h030;
	localparam logic [11:0] CFGIO_OFS_PIN_RD = 12'h034;
	localparam logic [11:0] CFGIO_OFS_PINOPT = 12'h038;
	localparam logic [7:0] CFGIO_LATCH_RST = 8'hff;
	localparam logic [7:0] CFGIO_MODE_A_RST = 8'hff;
	localparam logic [7:0] CFGIO_MODE_B_RST = 8'h00;
	localparam logic [7:0] CFGIO_AN_OFF_RST = 8'h00;
	localparam logic [7:0] CFGIO_AN_OFF_MASK = 8'h3e;
	localparam logic [1:0] CFGIO_STRONG_CYC = 2'h2;
	localparam int unsigned CFGIO_FILT_LEN = 2;
	typedef enum logic [1:0] {
		CFGIO_MODE_QUASI = 2'b00,
		CFGIO_MODE_PUSH = 2'b01,
		CFGIO_MODE_INPUT = 2'b10,
		CFGIO_MODE_OPEN = 2'b11
	} cfgio_mode_t;
	typedef struct packed {
		logic very_weak_up;
		logic weak_up;
		logic strong_up;
		logic pull_down;
	} cfgio_drive_t;
	typedef struct packed {
		logic [11:0] paddr;
		logic pwrite;
		logic [31:0] pwdata;
	} cfgio_apb_req_t;
endpackage : cfgio_pkg

// *** design/cfgio_port.sv ***
// Configurable port pins: mode registers, drivers, pull-up sequencing and input path.
// Behaviour
// - Three ports: two eight-bit, one two-bit.
// - Oscillator or reset pins leave general use.
// - Two mode bits select four output types.
// - Every pin has its own mode selection.
// - Port one bit five is always input.
// - Port one bits two, three never drive high.
// - Quasi mode: low strong, high weak.
// - Quasi very weak pull-up follows latch one.
// - Quasi weak pull-up needs latch and pin high.
// - Quasi strong pull-up two cycles on rise.
// - Open drain: no pull-ups, pull-down on zero.
// - Push-pull drives strong high on latch one.
// - Inputs are synchronised and glitch filtered.
// - Analog disable bits one-five map port zero.
// - Disabled digital inputs read as zero.
// - Reset clears analog disable bits.
// - Input-only mode disables all output drivers.
// - All configurable pins reset to input-only.
`timescale 1ns/1ps
`default_nettype none
module cfgio_port
	import cfgio_pkg::*;
#(
	parameter int unsigned FILT_LEN = CFGIO_FILT_LEN
) (
	input wire logic ref_clk,
	input wire logic srst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [CFGIO_NPIN-1:0] pin_i,
	output logic [CFGIO_NPIN-1:0] pin_o,
	output logic [CFGIO_NPIN-1:0] pin_oe_n,
	output logic [CFGIO_NPIN-1:0] very_weak_up,
	output logic [CFGIO_NPIN-1:0] weak_up,
	output logic [CFGIO_NPIN-1:0] strong_up,
	output logic [CFGIO_NPIN-1:0] pull_down,
	output logic [CFGIO_NPIN-1:0] pin_in_filt,
	output logic [CFGIO_NPIN-1:0] pin_usable
);
	logic [CFGIO_NPIN-1:0] latch_q;
	logic [CFGIO_NPIN-1:0] mode_a_q;
	logic [CFGIO_NPIN-1:0] mode_b_q;
	logic [7:0] an_off_q;
	logic [2:0] pinopt_q;
	logic [CFGIO_NPIN-1:0] latch_prev_q;
	logic [CFGIO_NPIN-1:0] sync1_q;
	logic [CFGIO_NPIN-1:0] sync2_q;
	logic [CFGIO_NPIN-1:0] filt_q;
	logic [CFGIO_NPIN-1:0] in_read;
	logic [CFGIO_NPIN-1:0] wr_latch;
	logic [CFGIO_NPIN-1:0] wr_mode_a;
	logic [CFGIO_NPIN-1:0] wr_mode_b;
	logic [1:0] strong_cnt_q [CFGIO_NPIN];
	logic [31:0] rdata_d;
	logic rd_ok;
	logic wr_en;
	logic wr_lane0;
	cfgio_apb_req_t req;

	assign req = '{paddr: paddr, pwrite: pwrite, pwdata: pwdata};
	assign pready = 1'b1;
	assign wr_en = psel && penable && req.pwrite;
	assign wr_lane0 = wr_en && pstrb[0];

	// Byte-wide register writes, each port register placed over the pin vector.
	always_comb begin
		wr_latch = '0;
		wr_mode_a = '0;
		wr_mode_b = '0;
		if (wr_lane0) begin
			unique case (req.paddr)
				CFGIO_OFS_P0_LATCH: wr_latch[7:0] = 8'hff;
				CFGIO_OFS_P0_MODE_A: wr_mode_a[7:0] = 8'hff;
				CFGIO_OFS_P0_MODE_B: wr_mode_b[7:0] = 8'hff;
				CFGIO_OFS_P1_LATCH: wr_latch[15:8] = 8'hff;
				CFGIO_OFS_P1_MODE_A: wr_mode_a[15:8] = 8'hff;
				CFGIO_OFS_P1_MODE_B: wr_mode_b[15:8] = 8'hff;
				CFGIO_OFS_P3_LATCH: wr_latch[17:16] = 2'h3;
				CFGIO_OFS_P3_MODE_A: wr_mode_a[17:16] = 2'h3;
				CFGIO_OFS_P3_MODE_B: wr_mode_b[17:16] = 2'h3;
				default: wr_latch = '0;
			endcase
		end
	end

	logic [CFGIO_NPIN-1:0] wdata_rep;
	assign wdata_rep = {req.pwdata[1:0], req.pwdata[7:0], req.pwdata[7:0]};

	// Latches and both mode registers; every pin starts input-only.
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			latch_q <= {CFGIO_LATCH_RST[1:0], CFGIO_LATCH_RST, CFGIO_LATCH_RST};
			mode_a_q <= {CFGIO_MODE_A_RST[1:0], CFGIO_MODE_A_RST, CFGIO_MODE_A_RST};
			mode_b_q <= {CFGIO_MODE_B_RST[1:0], CFGIO_MODE_B_RST, CFGIO_MODE_B_RST};
		end else begin
			latch_q <= (latch_q & ~wr_latch) | (wdata_rep & wr_latch);
			mode_a_q <= (mode_a_q & ~wr_mode_a) | (wdata_rep & wr_mode_a);
			mode_b_q <= (mode_b_q & ~wr_mode_b) | (wdata_rep & wr_mode_b);
		end
	end

	// Analog input disable; reset clears it, only bits one to five kept.
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			an_off_q <= CFGIO_AN_OFF_RST;
		end else if (wr_lane0 && req.paddr == CFGIO_OFS_AN_OFF) begin
			an_off_q <= req.pwdata[7:0] & CFGIO_AN_OFF_MASK;
		end
	end

	// Pin option: bit0 external reset, bit1 external clock, bit2 crystal.
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			pinopt_q <= 3'h0;
		end else if (wr_lane0 && req.paddr == CFGIO_OFS_PINOPT) begin
			pinopt_q <= req.pwdata[2:0];
		end
	end

	// Pins taken from general use by clock and reset options.
	always_comb begin
		pin_usable = '1;
		if (pinopt_q[0]) begin
			pin_usable[CFGIO_P1_B5] = 1'b0;
		end
		if (pinopt_q[1] || pinopt_q[2]) begin
			pin_usable[CFGIO_P3_B1] = 1'b0;
		end
		if (pinopt_q[2]) begin
			pin_usable[CFGIO_P3_B0] = 1'b0;
		end
	end

	// Two-stage synchroniser, then a filter that needs FILT_LEN plus one steady samples.
	logic [FILT_LEN-1:0] hist_q [CFGIO_NPIN];
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			sync1_q <= '0;
			sync2_q <= '0;
		end else begin
			sync1_q <= pin_i;
			sync2_q <= sync1_q;
		end
	end

	genvar g;
	generate
		for (g = 0; g < CFGIO_NPIN; g++) begin : g_pin
			cfgio_mode_t mode;
			logic cfg_in_only;
			logic cfg_open;
			logic rise;
			logic fixed_in;
			logic od_only;
			assign fixed_in = (g == CFGIO_P1_B5);
			assign od_only = (g == CFGIO_P1_B2) || (g == CFGIO_P1_B3);
			assign mode = cfgio_mode_t'({mode_a_q[g], mode_b_q[g]});
			// Bit five of port one is locked to input; bits two and three only OD.
			assign cfg_in_only = fixed_in || !pin_usable[g] ||
				(mode == CFGIO_MODE_INPUT) || (od_only && !mode_a_q[g]);
			assign cfg_open = !cfg_in_only && (od_only || mode == CFGIO_MODE_OPEN);

			always_ff @(posedge ref_clk) begin
				if (srst) begin
					hist_q[g] <= '0;
					filt_q[g] <= 1'b0;
				end else begin
					hist_q[g] <= {hist_q[g][FILT_LEN-2:0], sync2_q[g]};
					if (&{hist_q[g], sync2_q[g]}) begin
						filt_q[g] <= 1'b1;
					end else if (~|{hist_q[g], sync2_q[g]}) begin
						filt_q[g] <= 1'b0;
					end
				end
			end

			assign rise = latch_q[g] && !latch_prev_q[g];
			// Strong pull-up held two cycles after a zero-to-one latch change.
			always_ff @(posedge ref_clk) begin
				if (srst) begin
					latch_prev_q[g] <= 1'b1;
					strong_cnt_q[g] <= 2'h0;
				end else begin
					latch_prev_q[g] <= latch_q[g];
					if (rise && mode == CFGIO_MODE_QUASI && !cfg_in_only && !cfg_open) begin
						strong_cnt_q[g] <= CFGIO_STRONG_CYC;
					end else if (strong_cnt_q[g] != 2'h0) begin
						strong_cnt_q[g] <= strong_cnt_q[g] - 2'h1;
					end
				end
			end

			// Driver decode per mode.
			always_comb begin
				very_weak_up[g] = 1'b0;
				weak_up[g] = 1'b0;
				strong_up[g] = 1'b0;
				pull_down[g] = 1'b0;
				if (!cfg_in_only) begin
					pull_down[g] = !latch_q[g];
					if (!cfg_open && mode == CFGIO_MODE_QUASI) begin
						very_weak_up[g] = latch_q[g];
						weak_up[g] = latch_q[g] && filt_q[g];
						strong_up[g] = latch_q[g] && (strong_cnt_q[g] != 2'h0);
					end else if (!cfg_open && mode == CFGIO_MODE_PUSH) begin
						strong_up[g] = latch_q[g];
					end
				end
			end

			assign pin_o[g] = strong_up[g];
			assign pin_oe_n[g] = !(strong_up[g] || pull_down[g]);

			// Port zero pins one to five read zero while digital input is off.
			if (g >= 1 && g <= 5) begin : g_an
				assign in_read[g] = filt_q[g] && !an_off_q[g];
			end else begin : g_dig
				assign in_read[g] = filt_q[g];
			end
		end
	endgenerate

	assign pin_in_filt = in_read;

	// Read mux; unmapped addresses answer with an error.
	always_comb begin
		rdata_d = 32'h0;
		rd_ok = 1'b1;
		unique case (req.paddr)
			CFGIO_OFS_P0_LATCH: rdata_d[7:0] = latch_q[7:0];
			CFGIO_OFS_P0_MODE_A: rdata_d[7:0] = mode_a_q[7:0];
			CFGIO_OFS_P0_MODE_B: rdata_d[7:0] = mode_b_q[7:0];
			CFGIO_OFS_P1_LATCH: rdata_d[7:0] = latch_q[15:8];
			CFGIO_OFS_P1_MODE_A: rdata_d[7:0] = mode_a_q[15:8];
			CFGIO_OFS_P1_MODE_B: rdata_d[7:0] = mode_b_q[15:8];
			CFGIO_OFS_P3_LATCH: rdata_d[1:0] = latch_q[17:16];
			CFGIO_OFS_P3_MODE_A: rdata_d[1:0] = mode_a_q[17:16];
			CFGIO_OFS_P3_MODE_B: rdata_d[1:0] = mode_b_q[17:16];
			CFGIO_OFS_AN_OFF: rdata_d[7:0] = an_off_q;
			CFGIO_OFS_PIN_RD: rdata_d[17:0] = in_read;
			CFGIO_OFS_PINOPT: rdata_d[2:0] = pinopt_q;
			default: rd_ok = 1'b0;
		endcase
	end

	assign prdata = rdata_d;
	assign pslverr = psel && penable && !rd_ok;

	// Checks.
	// Strong pull-up on pin zero: two cycles high, then released.
	sequence s_strong_start;
		$rose(strong_up[0]) && mode_a_q[0] == 1'b0 && mode_b_q[0] == 1'b0 && latch_q[0];
	endsequence
	sequence s_strong_settled;
		$stable(mode_a_q[0]) && $stable(mode_b_q[0]) && $stable(latch_q[0]);
	endsequence
	sequence s_strong_pulse;
		strong_up[0] ##1 (!strong_up[0] || !latch_q[0] || $changed(mode_a_q[0]));
	endsequence
	chk_strong_two_cyc: assert property (@(posedge ref_clk) disable iff (srst)
		s_strong_start ##0 s_strong_settled |=> s_strong_pulse)
		else $error("strong pull-up not held for two cycles");

	chk_fixed_input: assert property (@(posedge ref_clk) disable iff (srst)
		pin_oe_n[CFGIO_P1_B5] && !very_weak_up[CFGIO_P1_B5] && !weak_up[CFGIO_P1_B5])
		else $error("fixed input pin driven");
	chk_no_high_od: assert property (@(posedge ref_clk) disable iff (srst)
		!strong_up[CFGIO_P1_B2] && !strong_up[CFGIO_P1_B3]
		&& !weak_up[CFGIO_P1_B2] && !weak_up[CFGIO_P1_B3]
		&& !very_weak_up[CFGIO_P1_B2] && !very_weak_up[CFGIO_P1_B3])
		else $error("open-drain-only pin sourced high");
	chk_open_drain: assert property (@(posedge ref_clk) disable iff (srst)
		(mode_a_q[0] && mode_b_q[0]) |-> !strong_up[0] && !weak_up[0] && !very_weak_up[0]
		&& pull_down[0] == !latch_q[0])
		else $error("open-drain drive wrong");
	chk_push_pull: assert property (@(posedge ref_clk) disable iff (srst)
		(!mode_a_q[0] && mode_b_q[0]) |-> strong_up[0] == latch_q[0])
		else $error("push-pull drive wrong");
	chk_input_only: assert property (@(posedge ref_clk) disable iff (srst)
		(mode_a_q[0] && !mode_b_q[0]) |-> pin_oe_n[0] && !very_weak_up[0])
		else $error("input-only pin driven");
	chk_weak_follows: assert property (@(posedge ref_clk) disable iff (srst)
		weak_up[0] |-> latch_q[0] && filt_q[0])
		else $error("weak pull-up on without latch and pin high");
	chk_an_read_zero: assert property (@(posedge ref_clk) disable iff (srst)
		an_off_q[3] |-> !in_read[3])
		else $error("disabled input read nonzero");
	chk_an_reset: assert property (@(posedge ref_clk)
		$past(srst) && !srst |-> an_off_q == 8'h00)
		else $error("analog disable not cleared by reset");
	chk_reset_input: assert property (@(posedge ref_clk)
		$past(srst) && !srst |-> pin_oe_n == '1)
		else $error("pin driven after reset");

	chk_strong_on_rise: assert property (@(posedge ref_clk) disable iff (srst)
		($rose(latch_q[0]) && !mode_a_q[0] && !mode_b_q[0])
		|=> strong_up[0] || !latch_q[0] || $changed(mode_a_q[0]) || $changed(mode_b_q[0]))
		else $error("strong pull-up missing after latch rise");

	chk_quasi_low: assert property (@(posedge ref_clk) disable iff (srst)
		(!mode_a_q[0] && !mode_b_q[0] && !latch_q[0])
		|-> pull_down[0] && !very_weak_up[0] && !weak_up[0])
		else $error("quasi low not driven strongly");

	chk_very_weak_on: assert property (@(posedge ref_clk) disable iff (srst)
		(!mode_a_q[0] && !mode_b_q[0] && latch_q[0]) |-> very_weak_up[0])
		else $error("very weak pull-up off with latch high");

	chk_weak_on: assert property (@(posedge ref_clk) disable iff (srst)
		(!mode_a_q[0] && !mode_b_q[0] && latch_q[0] && filt_q[0]) |-> weak_up[0])
		else $error("weak pull-up off with latch and pin high");

	chk_push_no_weak: assert property (@(posedge ref_clk) disable iff (srst)
		(!mode_a_q[0] && mode_b_q[0])
		|-> !very_weak_up[0] && !weak_up[0] && pull_down[0] == !latch_q[0])
		else $error("push-pull pulls wrong");

	chk_pin_o_driven: assert property (@(posedge ref_clk) disable iff (srst)
		pin_o[0] |-> !pin_oe_n[0] && strong_up[0])
		else $error("pin high level without strong drive");

	chk_an_upper: assert property (@(posedge ref_clk) disable iff (srst)
		(an_off_q & ~CFGIO_AN_OFF_MASK) == 8'h00)
		else $error("analog disable kept bits outside one to five");

	chk_an_others: assert property (@(posedge ref_clk) disable iff (srst)
		in_read[0] == filt_q[0] && in_read[6] == filt_q[6] && in_read[7] == filt_q[7])
		else $error("pin outside one to five masked");

	chk_an_pass: assert property (@(posedge ref_clk) disable iff (srst)
		!an_off_q[3] |-> in_read[3] == filt_q[3])
		else $error("enabled digital input not passed");

	chk_usable_all: assert property (@(posedge ref_clk) disable iff (srst)
		(pinopt_q == 3'h0) |-> (pin_usable == '1))
		else $error("pin lost with internal clock and no reset pin");

	chk_usable_clk: assert property (@(posedge ref_clk) disable iff (srst)
		(pinopt_q == 3'h2) |-> ($countones(pin_usable) == 17))
		else $error("usable pin count wrong with external clock");

	chk_usable_min: assert property (@(posedge ref_clk) disable iff (srst)
		(pinopt_q[0] && pinopt_q[2]) |-> ($countones(pin_usable) == 15))
		else $error("usable pin count wrong with crystal and reset pin");

	chk_filter_rise: assert property (@(posedge ref_clk) disable iff (srst)
		$rose(filt_q[0])
		|-> $past(sync2_q[0], 1) && $past(sync2_q[0], 2) && $past(sync2_q[0], 3))
		else $error("filtered input rose on a short pulse");

	chk_filter_fall: assert property (@(posedge ref_clk) disable iff (srst)
		$fell(filt_q[0])
		|-> !$past(sync2_q[0], 1) && !$past(sync2_q[0], 2) && !$past(sync2_q[0], 3))
		else $error("filtered input fell on a short pulse");

	chk_od_b2_input: assert property (@(posedge ref_clk) disable iff (srst)
		!mode_a_q[CFGIO_P1_B2] |-> pin_oe_n[CFGIO_P1_B2])
		else $error("open-drain-only pin driven while input-only");

	chk_od_b3_input: assert property (@(posedge ref_clk) disable iff (srst)
		!mode_a_q[CFGIO_P1_B3] |-> pin_oe_n[CFGIO_P1_B3])
		else $error("open-drain-only pin driven while input-only");

	chk_reset_modes: assert property (@(posedge ref_clk)
		$past(srst) && !srst |-> mode_a_q == '1 && mode_b_q == '0)
		else $error("modes not input-only after reset");
endmodule // cfgio_port
`default_nettype wire

// *** sim/cfgio_ext_model.sv ***
// External circuitry model that settles the level seen on each port pin.
`timescale 1ns/1ps
`default_nettype none
module cfgio_ext_model
	import cfgio_pkg::*;
(
	input wire logic ref_clk,
	input wire logic [CFGIO_NPIN-1:0] pin_o,
	input wire logic [CFGIO_NPIN-1:0] pin_oe_n,
	input wire logic [CFGIO_NPIN-1:0] very_weak_up,
	input wire logic [CFGIO_NPIN-1:0] weak_up,
	input wire logic [CFGIO_NPIN-1:0] ext_low,
	input wire logic [CFGIO_NPIN-1:0] ext_pullup,
	output logic [CFGIO_NPIN-1:0] pin_i
);
	logic [CFGIO_NPIN-1:0] float_q = '0;
	// An undriven pin with no pull wanders every cycle.
	always_ff @(posedge ref_clk) begin
		float_q <= ~float_q;
	end
	// An external sink overpowers the weak pull-ups.
	always_comb begin
		for (int i = 0; i < CFGIO_NPIN; i++) begin
			if (ext_low[i]) begin
				pin_i[i] = 1'b0;
			end else if (!pin_oe_n[i]) begin
				pin_i[i] = pin_o[i];
			end else if (very_weak_up[i] | weak_up[i] | ext_pullup[i]) begin
				pin_i[i] = 1'b1;
			end else begin
				pin_i[i] = float_q[i];
			end
		end
	end
endmodule // cfgio_ext_model
`default_nettype wire

// *** sim/test_configurable_io_port_pins.sv ***
// Self-checking testbench for the configurable port pin block.
`timescale 1ns/1ps
`default_nettype none
module test_configurable_io_port_pins;
	import cfgio_pkg::*;
	logic ref_clk = 0, srst = 1, psel = 0, penable = 0, pwrite = 0, pready, pslverr;
	logic [11:0] paddr = '0;
	logic [31:0] pwdata = '0, prdata, seed = 32'h14c3, lat;
	logic [CFGIO_NPIN-1:0] pin_i, pin_o, pin_oe_n, vw, wk, st, pd, filt, ext_low = '0, ext_up = '1;
	logic [CFGIO_NPIN-1:0] usable;
	logic [32:0] expq[$];
	int errors = 0, checks_done = 0, n;
	cfgio_port dut (.ref_clk(ref_clk), .srst(srst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .pin_i(pin_i), .pin_o(pin_o), .pin_oe_n(pin_oe_n),
		.very_weak_up(vw), .weak_up(wk), .strong_up(st), .pull_down(pd), .pin_in_filt(filt),
		.pin_usable(usable));
	cfgio_ext_model ext (.ref_clk(ref_clk), .pin_o(pin_o), .pin_oe_n(pin_oe_n),
		.very_weak_up(vw), .weak_up(wk), .ext_low(ext_low), .ext_pullup(ext_up), .pin_i(pin_i));
	initial begin
		forever #2 ref_clk = ~ref_clk;
	end
	function automatic logic [31:0] xs(input logic [31:0] s);
		s ^= s << 13;
		s ^= s >> 17;
		return s ^ (s << 5);
	endfunction
	task automatic results();
		$display("checks %0d errors %0d", checks_done, errors);
		if (errors == 0 && checks_done > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		checks_done++;
		if (got !== exp) begin
			errors++;
			$display("MISMATCH %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1;
		n = 0;
		do begin
			@(posedge ref_clk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		psel <= 0;
		penable <= 0;
		if (n >= 50) begin
			errors++;
			results();
		end
	endtask
	task automatic rd(input logic [11:0] a, input logic [32:0] exp);
		expq.push_back(exp);
		apb(0, a, 0);
	endtask
	task automatic reset_dut();
		srst <= 1;
		repeat (12) @(posedge ref_clk);
		srst <= 0;
	endtask
	// Read data is compared against the oldest note when the access completes.
	always @(posedge ref_clk) begin
		if (psel && penable && pready === 1'b1 && !pwrite && expq.size() > 0) begin
			chk({pslverr, prdata}, expq.pop_front());
		end
	end
	initial begin
		logic [1:0] m;
		reset_dut();
		rd(CFGIO_OFS_P0_LATCH, 32'hff);
		rd(CFGIO_OFS_P0_MODE_A, 32'hff);
		rd(CFGIO_OFS_P0_MODE_B, 32'h00);
		rd(CFGIO_OFS_AN_OFF, 32'h00);
		rd(12'hffc, 33'h1_0000_0000);
		chk({st, pd, ~pin_oe_n}, '0);
		$display("reset test done");
		for (int k = 0; k < 4; k++) begin
			m = k[1:0];
			seed = xs(seed);
			lat = {24'h0, seed[7:0]};
			apb(1, CFGIO_OFS_P0_MODE_A, {32{m[1]}});
			apb(1, CFGIO_OFS_P0_MODE_B, {32{m[0]}});
			apb(1, CFGIO_OFS_P0_LATCH, 32'hff);
			apb(1, CFGIO_OFS_P0_LATCH, lat);
			repeat (6) @(posedge ref_clk);
			case (m)
				2'b00: chk({vw[7:0], st[7:0], pd[7:0]}, {lat[7:0], 8'h0, ~lat[7:0]});
				2'b01: chk({vw[7:0], st[7:0], pd[7:0]}, {8'h0, lat[7:0], ~lat[7:0]});
				2'b10: chk({vw[7:0], st[7:0], pd[7:0]}, 24'h0);
				default: chk({vw[7:0], st[7:0], pd[7:0]}, {16'h0, ~lat[7:0]});
			endcase
		end
		$display("mode test done");
		apb(1, CFGIO_OFS_P0_MODE_A, 0);
		apb(1, CFGIO_OFS_P0_MODE_B, 0);
		apb(1, CFGIO_OFS_P0_LATCH, 0);
		apb(1, CFGIO_OFS_P0_LATCH, 32'hff);
		n = 0;
		repeat (10) begin
			@(posedge ref_clk);
			n += st[0];
		end
		chk(n, 2);
		ext_low[0] <= 1;
		repeat (10) @(posedge ref_clk);
		chk({vw[0], wk[0]}, 2'b10);
		ext_low[0] <= 0;
		repeat (10) @(posedge ref_clk);
		chk({vw[0], wk[0]}, 2'b11);
		$display("quasi test done");
		apb(1, CFGIO_OFS_P1_MODE_A, 0);
		apb(1, CFGIO_OFS_P1_MODE_B, 32'hff);
		repeat (4) @(posedge ref_clk);
		chk(st[15:8], 8'hd3);
		apb(1, CFGIO_OFS_P1_MODE_A, 32'hff);
		apb(1, CFGIO_OFS_P1_LATCH, 0);
		repeat (4) @(posedge ref_clk);
		chk({st[15:8], pd[15:8]}, 16'h00df);
		apb(1, CFGIO_OFS_P1_LATCH, 32'hff);
		$display("port one test done");
		apb(1, CFGIO_OFS_P0_MODE_A, 32'hff);
		apb(1, CFGIO_OFS_AN_OFF, 32'hff);
		repeat (10) @(posedge ref_clk);
		rd(CFGIO_OFS_PIN_RD, 32'h3ffc1);
		rd(CFGIO_OFS_AN_OFF, 32'h3e);
		chk(filt, 18'h3ffc1);
		apb(1, CFGIO_OFS_PINOPT, 32'h2);
		repeat (2) @(posedge ref_clk);
		chk(usable, 18'h1ffff);
		apb(1, CFGIO_OFS_PINOPT, 32'h5);
		repeat (2) @(posedge ref_clk);
		chk(usable, 18'h0dfff);
		reset_dut();
		rd(CFGIO_OFS_AN_OFF, 32'h0);
		chk(usable, 18'h3ffff);
		$display("analog test done");
		repeat (4) @(posedge ref_clk);
		results();
	end
endmodule // test_configurable_io_port_pins
`default_nettype wire
